// ==== pkg/mspf_pkg.sv ====
// Behaviour
// - Command 0x15 is the phase compensation packet, acknowledged with 0x45.
// - Phase compensation bytes 2-7: A low, A high, B low, B high, C low, C high.
// - Command 0x0E is the DC offset packet, acknowledged with 0x3E.
// - DC offset bytes 2-7: 16-bit offsets A, B, C, high byte first.
// - Positions without legal value are zero; bytes 8 and 9 of write packets.
// - Byte 1 is start marker 0xEE, byte 10 is the checksum.
// - Command 0x0F returns a voltage packet acknowledged with 0x3F.
// - Voltage packet bytes 2-7: voltages A, B, C high byte first; byte 9 unused.
// - Voltage byte 8: tamper bits, reversal A, B, C, then phase sequence error.
// - Voltages are unsigned counts of hundredths of a volt.
// - Command 0x10 returns a current packet acknowledged with 0x40.
// - Current packet bytes 2-7: currents A, B, C, high byte first.
// - Current packet bytes 8-9: line frequency word, high byte in byte 8.
// - Currents are unsigned counts of thousandths of an ampere.
// - Command 0x11 returns a power and energy packet acknowledged with 0x41.
// - Power packet bytes 2-5: total power, most significant byte first.
// - Power packet bytes 6-9: total energy, most significant byte first.
// - Power is an unsigned count of 0.00001 kW.
// - Energy is an unsigned count of 0.0001 kWh.
// - Checksum equals the sum of bytes 1 to 9, marker included.
// - Acknowledgement code is the received command plus 0x30.
// - Every packet is exactly ten bytes long.
`default_nettype none
package mspf_pkg;
  // ==========================================================
  // Packet framing
  localparam logic [3:0] PKT_LAST_IDX        = 4'h9;
  localparam logic [3:0] IDX_MARK            = 4'h0;
  localparam logic [3:0] IDX_LAST_DATA       = 4'h8;
  localparam logic [7:0] PACKET_START_MARKER = 8'hEE;
  localparam logic [7:0] ZERO_PAD_BYTE       = 8'h00;
  localparam logic [7:0] ACK_OFFSET          = 8'h30;
  localparam logic [7:0] CMD_PHASE_COMP      = 8'h15;
  localparam logic [7:0] ACK_PHASE_COMP      = 8'h45;
  localparam logic [7:0] CMD_DC_OFFSET       = 8'h0E;
  localparam logic [7:0] ACK_DC_OFFSET       = 8'h3E;
  localparam logic [7:0] CMD_VOLTS           = 8'h0F;
  localparam logic [7:0] ACK_VOLTS           = 8'h3F;
  localparam logic [7:0] CMD_AMPS            = 8'h10;
  localparam logic [7:0] ACK_AMPS            = 8'h40;
  localparam logic [7:0] CMD_POWER           = 8'h11;
  localparam logic [7:0] ACK_POWER           = 8'h41;
  // ==========================================================
  // Register map
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COMP0  = 12'h008;
  localparam logic [11:0] REG_COMP1  = 12'h00C;
  localparam logic [11:0] REG_OFFS0  = 12'h010;
  localparam logic [11:0] REG_OFFS1  = 12'h014;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_EN_BIT  = 0;
  localparam int ST_SUM_ERR   = 0;
  localparam int ST_MARK_ERR  = 1;
  localparam int ST_UNK_CMD   = 2;
  localparam int ST_OVERRUN   = 3;
  localparam int ST_CMD_LSB   = 8;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    KIND_VOLTS = 2'b00,
    KIND_AMPS  = 2'b01,
    KIND_POWER = 2'b10,
    KIND_NONE  = 2'b11
  } mspf_kind_t;
  typedef enum logic {
    RX_CMD = 1'b0,
    RX_PKT = 1'b1
  } mspf_rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ACK  = 2'b01,
    TX_PKT  = 2'b10
  } mspf_tx_state_t;
  // Tamper nibble: bit0 A reversal, bit1 B, bit2 C, bit3 sequence error
  typedef struct packed {
    logic [15:0] volts_a;
    logic [15:0] volts_b;
    logic [15:0] volts_c;
    logic [3:0]  tamper;
    logic [15:0] amps_a;
    logic [15:0] amps_b;
    logic [15:0] amps_c;
    logic [15:0] line_frequency_word;
    logic [31:0] total_power;
    logic [31:0] total_energy;
  } mspf_meas_t;
  typedef struct packed {
    logic [7:0] phase_comp_low_a;
    logic [7:0] phase_comp_high_a;
    logic [7:0] phase_comp_low_b;
    logic [7:0] phase_comp_high_b;
    logic [7:0] phase_comp_low_c;
    logic [7:0] phase_comp_high_c;
  } mspf_comp_t;
  typedef struct packed {
    logic [15:0] offset_a;
    logic [15:0] offset_b;
    logic [15:0] offset_c;
  } mspf_offs_t;
endpackage
`default_nettype wire

// ==== verilog/mspf_sum.sv ====
`default_nettype none
// ==========================================================
// Running byte sum, carry beyond eight bits dropped
module mspf_sum
  import mspf_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] data,
  output var  logic [7:0] sum_ff
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_ff <= 8'h00;
    end else if (clr) begin
      sum_ff <= 8'h00;
    end else if (add) begin
      sum_ff <= sum_ff + data;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/mspf_framer.sv ====
`default_nettype none
module mspf_framer
  import mspf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output var  logic        tx_valid,
  output var  logic [7:0]  tx_byte,
  input  wire logic        tx_ready,
  input  wire mspf_meas_t  meas,
  output var  mspf_comp_t  comp,
  output var  mspf_offs_t  offs
);
  // ==========================================================
  // Declarations
  logic [31:0]    ctrl_ff;
  logic [3:0]     flags_ff;
  logic [7:0]     last_cmd_ff;
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;
  mspf_rx_state_t rx_state_ff;
  logic [3:0]     rx_idx_ff;
  logic [7:0]     rx_cmd_ff;
  logic [7:0]     rx_buf_ff [1:8];
  logic [7:0]     rx_sum;
  mspf_tx_state_t tx_state_ff;
  logic [3:0]     tx_idx_ff;
  logic [7:0]     tx_cmd_ff;
  logic           tx_pkt_ff;
  mspf_kind_t     tx_kind_ff;
  logic           tx_valid_ff;
  logic [7:0]     tx_byte_ff;
  logic [7:0]     tx_sum;
  mspf_meas_t     snap_ff;
  mspf_comp_t     comp_ff;
  mspf_offs_t     offs_ff;
  logic           rx_take;
  logic           tx_hs;
  logic           cmd_is_write;
  mspf_kind_t     cmd_kind;
  logic           pkt_good;
  logic           req_valid;
  logic [7:0]     req_cmd;
  logic           req_pkt;
  mspf_kind_t     req_kind;
  logic           req_go;
  logic [3:0]     ev_flags;
  logic           apb_rd;
  logic           apb_wr;
  logic           mapped;
  logic [31:0]    rd_mux;

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_byte  = tx_byte_ff;
  assign comp     = comp_ff;
  assign offs     = offs_ff;

  // ==========================================================
  // Payload byte of a readout packet, index 1 to 8
  function automatic logic [7:0] payload(mspf_kind_t k, logic [3:0] i, mspf_meas_t m);
    logic [63:0] w;
    int          j;
    w = 64'h0;
    j = 8 - int'(i);
    case (k)
      KIND_VOLTS: w = {m.volts_a, m.volts_b, m.volts_c,
                       4'h0, m.tamper, ZERO_PAD_BYTE};
      KIND_AMPS:  w = {m.amps_a, m.amps_b, m.amps_c,
                       m.line_frequency_word};
      KIND_POWER: w = {m.total_power, m.total_energy};
      default:    w = 64'h0;
    endcase
    if (j < 0 || j > 7) begin
      payload = ZERO_PAD_BYTE;
    end else begin
      payload = w[8*j +: 8];
    end
  endfunction

  // ==========================================================
  // Command decode
  always_comb begin
    cmd_is_write = (rx_byte == CMD_PHASE_COMP) || (rx_byte == CMD_DC_OFFSET);
    case (rx_byte)
      CMD_VOLTS: cmd_kind = KIND_VOLTS;
      CMD_AMPS:  cmd_kind = KIND_AMPS;
      CMD_POWER: cmd_kind = KIND_POWER;
      default:   cmd_kind = KIND_NONE;
    endcase
  end

  // Host drives every exchange; device only answers
  assign rx_take  = rx_valid && ctrl_ff[CTRL_EN_BIT];
  assign tx_hs    = tx_valid_ff && tx_ready;
  assign pkt_good = (rx_state_ff == RX_PKT) && rx_take && (rx_idx_ff == PKT_LAST_IDX) && (rx_byte == rx_sum);

  // ==========================================================
  // Answer requests: ack alone for writes, ack plus packet for reads
  always_comb begin
    req_valid = 1'b0;
    req_cmd   = rx_byte;
    req_pkt   = 1'b0;
    req_kind  = KIND_NONE;
    if (rx_state_ff == RX_CMD && rx_take && cmd_kind != KIND_NONE) begin
      req_valid = 1'b1;
      req_pkt   = 1'b1;
      req_kind  = cmd_kind;
    end else if (pkt_good) begin
      req_valid = 1'b1;
      req_cmd   = rx_cmd_ff;
    end
  end
  // A busy transmitter drops the answer; host retries on timeout
  assign req_go = req_valid && (tx_state_ff == TX_IDLE);

  always_comb begin
    ev_flags              = 4'h0;
    ev_flags[ST_SUM_ERR]  = (rx_state_ff == RX_PKT) && rx_take && (rx_idx_ff == PKT_LAST_IDX) && (rx_byte != rx_sum);
    ev_flags[ST_MARK_ERR] = (rx_state_ff == RX_PKT) && rx_take && (rx_idx_ff == IDX_MARK)
                            && (rx_byte != PACKET_START_MARKER);
    ev_flags[ST_UNK_CMD]  = (rx_state_ff == RX_CMD) && rx_take && !cmd_is_write && (cmd_kind == KIND_NONE);
    ev_flags[ST_OVERRUN]  = req_valid && (tx_state_ff != TX_IDLE);
  end

  // ==========================================================
  // Receive framing
  mspf_sum u_rx_sum (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (rx_state_ff == RX_CMD),
    .add     ((rx_state_ff == RX_PKT) && rx_take && (rx_idx_ff <= IDX_LAST_DATA)),
    .data    (rx_byte),
    .sum_ff  (rx_sum)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_ff <= RX_CMD;
      rx_idx_ff   <= 4'h0;
      rx_cmd_ff   <= 8'h00;
    end else if (rx_take) begin
      case (rx_state_ff)
        RX_CMD: begin
          if (cmd_is_write) begin
            rx_state_ff <= RX_PKT;
            rx_cmd_ff   <= rx_byte;
            rx_idx_ff   <= 4'h0;
          end
        end
        RX_PKT: begin
          if (rx_idx_ff == IDX_MARK && rx_byte != PACKET_START_MARKER) begin
            rx_state_ff <= RX_CMD;
          end else if (rx_idx_ff == PKT_LAST_IDX) begin
            rx_state_ff <= RX_CMD;
          end else begin
            rx_idx_ff <= rx_idx_ff + 4'h1;
          end
        end
        default: rx_state_ff <= RX_CMD;
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (rx_state_ff == RX_PKT && rx_take && rx_idx_ff >= 4'h1 && rx_idx_ff <= IDX_LAST_DATA) begin
      rx_buf_ff[rx_idx_ff] <= rx_byte;
    end
  end

  // Constants change only on a clean packet; pad bytes 8 and 9 are not used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_ff <= '0;
      offs_ff <= '0;
    end else if (pkt_good) begin
      if (rx_cmd_ff == CMD_PHASE_COMP) begin
        comp_ff <= {rx_buf_ff[1], rx_buf_ff[2], rx_buf_ff[3], rx_buf_ff[4], rx_buf_ff[5], rx_buf_ff[6]};
      end
      if (rx_cmd_ff == CMD_DC_OFFSET) begin
        offs_ff <= {rx_buf_ff[1], rx_buf_ff[2], rx_buf_ff[3], rx_buf_ff[4], rx_buf_ff[5], rx_buf_ff[6]};
      end
    end
  end

  // ==========================================================
  // Transmit framing
  mspf_sum u_tx_sum (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (tx_state_ff != TX_PKT),
    .add     ((tx_state_ff == TX_PKT) && tx_hs && (tx_idx_ff <= IDX_LAST_DATA)),
    .data    (tx_byte_ff),
    .sum_ff  (tx_sum)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_ff <= TX_IDLE;
      tx_idx_ff   <= 4'h0;
      tx_cmd_ff   <= 8'h00;
      tx_pkt_ff   <= 1'b0;
      tx_kind_ff  <= KIND_NONE;
      tx_valid_ff <= 1'b0;
      tx_byte_ff  <= 8'h00;
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          if (req_go) begin
            tx_state_ff <= TX_ACK;
            tx_cmd_ff   <= req_cmd;
            tx_pkt_ff   <= req_pkt;
            tx_kind_ff  <= req_kind;
            tx_valid_ff <= 1'b1;
            tx_byte_ff  <= req_cmd + ACK_OFFSET;
          end
        end
        TX_ACK: begin
          if (tx_hs) begin
            if (tx_pkt_ff) begin
              tx_state_ff <= TX_PKT;
              tx_idx_ff   <= IDX_MARK;
              tx_byte_ff  <= PACKET_START_MARKER;
            end else begin
              tx_state_ff <= TX_IDLE;
              tx_valid_ff <= 1'b0;
            end
          end
        end
        TX_PKT: begin
          if (tx_hs) begin
            if (tx_idx_ff == PKT_LAST_IDX) begin
              tx_state_ff <= TX_IDLE;
              tx_valid_ff <= 1'b0;
            end else if (tx_idx_ff == IDX_LAST_DATA) begin
              tx_idx_ff  <= PKT_LAST_IDX;
              tx_byte_ff <= tx_sum + tx_byte_ff;
            end else begin
              tx_idx_ff  <= tx_idx_ff + 4'h1;
              tx_byte_ff <= payload(tx_kind_ff, tx_idx_ff + 4'h1, snap_ff);
            end
          end
        end
        default: begin
          tx_state_ff <= TX_IDLE;
          tx_valid_ff <= 1'b0;
        end
      endcase
    end
  end

  // Snapshot keeps one packet self-consistent while the datapath moves on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_ff <= '0;
    end else if (req_go && req_pkt) begin
      snap_ff <= meas;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  assign apb_rd = psel && penable && !pready_ff && !pwrite;
  assign apb_wr = psel && penable && pready_ff && pwrite;
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      REG_CTRL:   rd_mux = ctrl_ff;
      REG_STATUS: rd_mux = {16'h0, last_cmd_ff, 4'h0, flags_ff};
      REG_COMP0:  rd_mux = {comp_ff.phase_comp_high_b, comp_ff.phase_comp_low_b,
                            comp_ff.phase_comp_high_a, comp_ff.phase_comp_low_a};
      REG_COMP1:  rd_mux = {16'h0, comp_ff.phase_comp_high_c, comp_ff.phase_comp_low_c};
      REG_OFFS0:  rd_mux = {offs_ff.offset_b, offs_ff.offset_a};
      REG_OFFS1:  rd_mux = {16'h0, offs_ff.offset_c};
      default:    mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
      if (apb_rd) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (apb_wr && paddr == REG_CTRL) begin
      ctrl_ff <= {31'h0, pwdata[CTRL_EN_BIT]};
    end
  end

  // Write one clears; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff    <= 4'h0;
      last_cmd_ff <= 8'h00;
    end else begin
      if (apb_wr && paddr == REG_STATUS) begin
        flags_ff <= (flags_ff & ~pwdata[3:0]) | ev_flags;
      end else begin
        flags_ff <= flags_ff | ev_flags;
      end
      if (rx_state_ff == RX_CMD && rx_take) begin
        last_cmd_ff <= rx_byte;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_ack_code: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_ACK) |-> tx_byte_ff == 8'(tx_cmd_ff + 8'h30))
    else $error("ack code is not command plus 0x30");
  chk_read_ack: assert property (@(posedge pclk) disable iff (!presetn)
    (req_go && rx_byte == CMD_VOLTS && rx_state_ff == RX_CMD) |=> tx_byte_ff == ACK_VOLTS && tx_valid_ff)
    else $error("voltage command not acknowledged with 0x3F");
  chk_pkt_marker: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_ACK && tx_hs && tx_pkt_ff) |=> tx_state_ff == TX_PKT && tx_byte_ff == 8'hEE)
    else $error("packet does not open with start marker");
  chk_pkt_length: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_PKT && tx_hs && tx_idx_ff == 4'h9) |=> tx_state_ff == TX_IDLE && !tx_valid_ff)
    else $error("packet did not end after ten bytes");
  chk_tx_sum: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_PKT && tx_hs && tx_idx_ff == 4'h8) |=> tx_byte_ff == 8'($past(tx_sum) + $past(tx_byte_ff)))
    else $error("checksum byte wrong");
  chk_volt_pad: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_PKT && tx_kind_ff == KIND_VOLTS && tx_idx_ff == 4'h8) |-> tx_byte_ff == 8'h00)
    else $error("unused voltage byte not zero");
  chk_tamper_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_PKT && tx_kind_ff == KIND_VOLTS && tx_idx_ff == 4'h7) |-> tx_byte_ff == {4'h0, snap_ff.tamper})
    else $error("tamper byte wrong");
  chk_freq_high: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_PKT && tx_kind_ff == KIND_AMPS && tx_idx_ff == 4'h7)
    |-> tx_byte_ff == snap_ff.line_frequency_word[15:8])
    else $error("frequency high byte not in byte 8");
  chk_power_msb: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_state_ff == TX_PKT && tx_kind_ff == KIND_POWER && tx_idx_ff == 4'h1) |-> tx_byte_ff == snap_ff.total_power[31:24])
    else $error("power not most significant byte first");
  chk_comp_store: assert property (@(posedge pclk) disable iff (!presetn)
    (pkt_good && rx_cmd_ff == CMD_PHASE_COMP && tx_state_ff == TX_IDLE)
    |=> comp_ff.phase_comp_low_a == $past(rx_buf_ff[1])
    && comp_ff.phase_comp_high_c == $past(rx_buf_ff[6]) && tx_byte_ff == ACK_PHASE_COMP)
    else $error("phase constants not stored or acknowledged");
  chk_offs_store: assert property (@(posedge pclk) disable iff (!presetn)
    (pkt_good && rx_cmd_ff == CMD_DC_OFFSET) |=> offs_ff.offset_a == {$past(rx_buf_ff[1]), $past(rx_buf_ff[2])})
    else $error("offset A not stored high byte first");
endmodule
`default_nettype wire

// ==== verif/mspf_host.sv ====
`default_nettype none
module mspf_host (
  input  wire logic       pclk,
  input  wire logic       slow,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_byte,
  output var  logic       tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  logic       ph = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  // ==========================================
  // Host sends, one byte per call
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Inverted so a stale byte never looks valid
    rx_byte <= ~b;
  endtask
  // Command, then marker, six data, two pads, sum
  task automatic send_pkt(input logic [7:0] c, input logic [47:0] d, input logic bad);
    logic [7:0] s;
    s = 8'hEE;
    send(c);
    send(8'hEE);
    for (int i = 5; i >= 0; i--) begin
      send(d[i*8+:8]);
      s += d[i*8+:8];
    end
    send(8'h00);
    send(8'h00);
    send(s ^ {7'h00, bad});
  endtask
  // ==========================================
  // Receive side, stalls every other cycle when slow
  always @(posedge pclk) begin
    ph <= ~ph;
    tx_ready <= slow ? ph : 1'b1;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_byte);
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_meter_spi_packet_framer.sv ====
`default_nettype none
module tb_meter_spi_packet_framer;
  import mspf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] ack;
    logic       slow;
  } mspf_row_t;
  // ==========================================
  // Signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rx_valid, tx_valid, tx_ready;
  logic [7:0]  rx_byte, tx_byte, s;
  logic        slow = 1'b0;
  mspf_meas_t  meas;
  mspf_comp_t  comp;
  mspf_offs_t  offs;
  logic [31:0] rd;
  logic [71:0] ex;
  logic        err;
  int          bad_count = 0;
  int          checks = 0;
  mspf_row_t   rows[3] = '{'{CMD_VOLTS, ACK_VOLTS, 1'b0}, '{CMD_AMPS, ACK_AMPS, 1'b0},
                           '{CMD_POWER, ACK_POWER, 1'b1}};
  always #12.5 pclk = ~pclk;
  mspf_framer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .meas, .comp, .offs);
  mspf_host u_host (.pclk, .slow, .rx_valid, .rx_byte, .tx_ready, .tx_valid, .tx_byte);
  // ==========================================
  // Helpers
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a slave that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_got(input int n);
    int t;
    t = 0;
    while (u_host.got.size() < n && t < 400) begin
      @(posedge pclk);
      t++;
    end
    repeat (6) @(posedge pclk);
  endtask
  // Marker plus the eight payload bytes of each readout
  function automatic logic [71:0] body(input logic [7:0] c);
    case (c)
      CMD_VOLTS: body = {8'hEE, meas.volts_a, meas.volts_b, meas.volts_c, 4'h0, meas.tamper, 8'h00};
      CMD_AMPS:  body = {8'hEE, meas.amps_a, meas.amps_b, meas.amps_c, meas.line_frequency_word};
      default:   body = {8'hEE, meas.total_power, meas.total_energy};
    endcase
  endfunction
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run needs under 2000 cycles, limit is 40000
  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
  // ==========================================
  // Sequence
  initial begin
    meas = {16'h5A10, 16'h5A11, 16'hFF12, 4'hB, 16'h278B, 16'h278C, 16'hF78D, 16'h1388,
            32'h000D_1C4A, 32'h89AB_CDEF};
    repeat (16) @(posedge pclk);
    chk({tx_valid, pready, pslverr, comp, offs}, '0);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk({rd, err}, {CTRL_RESET, 1'b0});
    apb(1'b0, 12'h020, 32'h0);
    chk({err, pready}, 2'b11);
    $display("Test registers done");
    foreach (rows[i]) begin
      slow <= rows[i].slow;
      u_host.got.delete();
      u_host.send(rows[i].cmd);
      wait_got(11);
      ex = body(rows[i].cmd);
      s = 8'h00;
      chk(u_host.got.size(), 11);
      chk(u_host.got[0], rows[i].ack);
      for (int k = 0; k < 9; k++) begin
        s += ex[71-8*k-:8];
        chk(u_host.got[k+1], ex[71-8*k-:8]);
      end
      chk(u_host.got[10], s);
      $display("Test readout %h done", rows[i].cmd);
    end
    slow <= 1'b0;
    u_host.got.delete();
    u_host.send_pkt(CMD_PHASE_COMP, 48'h1122_3344_5566, 1'b0);
    wait_got(1);
    chk(u_host.got.size(), 1);
    chk(u_host.got[0], ACK_PHASE_COMP);
    chk(comp, 48'h1122_3344_5566);
    apb(1'b0, REG_COMP0, 32'h0);
    chk(rd, 32'h4433_2211);
    u_host.got.delete();
    u_host.send_pkt(CMD_DC_OFFSET, 48'hA1B2_C3D4_E5F6, 1'b0);
    wait_got(1);
    chk(u_host.got[0], ACK_DC_OFFSET);
    chk(offs, 48'hA1B2_C3D4_E5F6);
    apb(1'b0, REG_OFFS0, 32'h0);
    chk(rd, 32'hC3D4_A1B2);
    apb(1'b0, REG_OFFS1, 32'h0);
    chk(rd, 32'h0000_E5F6);
    apb(1'b0, REG_COMP1, 32'h0);
    chk(rd, 32'h0000_6655);
    $display("Test write packets done");
    u_host.got.delete();
    u_host.send_pkt(CMD_DC_OFFSET, 48'h0102_0304_0506, 1'b1);
    wait_got(1);
    chk(u_host.got.size(), 0);
    chk(offs, 48'hA1B2_C3D4_E5F6);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0E01);
    apb(1'b1, REG_STATUS, 32'h0000_000F);
    // Unknown command, bad marker, then a read that overlaps a busy transmitter
    u_host.send(8'h55);
    u_host.send(CMD_PHASE_COMP);
    u_host.send(8'h12);
    u_host.send(CMD_VOLTS);
    u_host.send(CMD_AMPS);
    wait_got(11);
    chk(u_host.got.size(), 11);
    chk(u_host.got[0], ACK_VOLTS);
    chk(comp, 48'h1122_3344_5566);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0000_100E);
    u_host.got.delete();
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    u_host.send(CMD_VOLTS);
    wait_got(1);
    chk(u_host.got.size(), 0);
    apb(1'b1, REG_CTRL, 32'h1);
    $display("Test refusals done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({tx_valid, comp, offs}, '0);
    presetn <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    chk({rd, err}, 33'h0);
    $display("Test second reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
